// ### core/dwp_pkg.sv
// dwp_pkg: register map, field positions, mode codes and carrier types of the
// dithered / up-down waveform generator.
// assumes a 32-bit APB master and a single pclk domain.
package dwp_pkg;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_SEL = 6'h04;
  localparam logic [5:0] OFS_CLK = 6'h08;
  localparam logic [5:0] OFS_STAT = 6'h0C;
  localparam logic [5:0] OFS_CNT_H = 6'h10;
  localparam logic [5:0] OFS_CNT_L = 6'h14;
  localparam logic [5:0] OFS_PER_H = 6'h18;
  localparam logic [5:0] OFS_PER_L = 6'h1C;
  localparam logic [5:0] OFS_DUTY_H = 6'h20;
  localparam logic [5:0] OFS_DUTY_L = 6'h24;
  localparam logic [5:0] OFS_TRIM_H = 6'h28;
  localparam logic [5:0] OFS_TRIM_L = 6'h2C;

  // control word fields
  localparam int CTRL_ON = 7;
  localparam int CTRL_MODE = 5;
  localparam int CTRL_TRIG = 3;
  localparam int CTRL_CLR = 2;
  localparam int CTRL_OE = 0;
  // select word fields: pin p uses nibble p
  localparam int SEL_WSEL = 0;
  localparam int SEL_PHASE = 3;
  localparam int SEL_NIB = 4;
  // clock word fields
  localparam int CLK_SRC = 0;
  localparam int CLK_DIV = 2;
  localparam int CLK_DIR = 4;
  // status word fields
  localparam int STAT_FLAG = 0;
  localparam int STAT_IEN = 1;
  localparam int STAT_DITH = 2;
  localparam int STAT_UD = 3;
  localparam int STAT_DOWN = 4;

  // mode codes
  localparam logic [1:0] MODE_17BIT = 2'h1;
  localparam logic [1:0] MODE_8P8 = 2'h3;
  localparam logic [1:0] TRIG_ALWAYS = 2'h0;
  localparam logic [2:0] WSEL_DITHER = 3'h4;
  localparam logic [2:0] WSEL_UPDOWN = 3'h5;
  localparam logic [1:0] SRC_PCLK = 2'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [5:0] paddr;
    logic [31:0] pwdata;
  } dwp_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dwp_apb_rsp_t;

endpackage

// ### core/dwp_wave_timer.sv
// dwp_wave_timer: APB-programmed timer with an 8+8 dithered waveform and a
// 17-bit up/down waveform, routed to two pins through phase selectors.
// assumes ext_tick pins are asynchronous; everything else is on pclk.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - 8+8 mode: 8-bit up counter, period, duty and trim from low bytes
// - dithered wave needs mode 11, select 100, trigger 00
// - 8+8: low count equal to duty raises dithered wave
// - 8+8: count equal to period drops wave, flags, restarts, may interrupt
// - trim bits weigh one half down to 1/256 of periods at width N
// - group length is two to the power of eight minus the lowest set trim bit position
// - bit 7 shortens odd periods, bit 0 period 128, never period 0
// - frequency is tick over period plus one; trim adds fractional duty
// - up/down wave needs mode 01, select 101, trigger 00
// - up/down: counting up, equal to second compare raises wave
// - up/down: equal to period compare reverses to counting down
// - up/down: counting up, further equal to duty compare drops wave
// - up/down: back at zero flags overflow, counts up, may interrupt
// - tick comes from selectable source then selectable divider
// - pin driven only with output enable and direction set; phase selectable
// - timer off stops counting and disables outputs; on starts it
// - phase 0 inverts the waveform, phase 1 passes it
// - compare takes effect only on low byte write, high byte first
// - count clear resets counter to zero and reads back zero
module dwp_wave_timer #(
  parameter int PRESC_W = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire dwp_pkg::dwp_apb_req_t apb_req,
  output var dwp_pkg::dwp_apb_rsp_t apb_rsp,
  // external tick sources 1..3
  input wire logic [2:0] ext_tick,
  // waveform pins
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  // overflow interrupt request
  output logic irq
);

  if (PRESC_W < 3) begin : g_bad_presc
    $error("PRESC_W must be at least 3 for divide by 8");
  end

  typedef struct packed {
    dwp_pkg::dwp_apb_rsp_t rsp;
    logic on;
    logic [1:0] mode;
    logic [1:0] trig;
    logic [1:0] oe_en;
    logic [7:0] sel;
    logic [1:0] clk_src;
    logic [1:0] clk_div;
    logic [1:0] pin_dir;
    logic [15:0] per;
    logic [15:0] duty;
    logic [15:0] trim;
    logic [2:0][7:0] hi_shadow;
    logic [15:0] cnt;
    logic dir_down;
    logic [7:0] idx;
    logic [7:0] lp;
    logic [7:0] ld;
    logic [7:0] lt;
    logic dith;
    logic ud;
    logic flag;
    logic irq_en;
    logic irq;
    logic [2:0][2:0] sync;
    logic [2:0] ext_lvl;
    logic [PRESC_W-1:0] presc;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
  } dwp_state_t;

  dwp_state_t s;
  dwp_state_t n;

  logic acc;
  logic wr;
  logic ctrl_wr;
  logic clr;
  logic restart;
  logic w1c;
  logic tick;
  logic src_ev;
  logic ovf;
  logic shorten;
  logic [7:0] cnt_lo_inc;
  logic [7:0] duty_eff;
  logic [2:0] agree;
  logic [2:0] ext_rise;
  logic [PRESC_W-1:0] div_mask;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [2:0] wsel;
  logic wave;

  // a period is shortened when the trim bit matching its lowest set index bit is set
  function automatic logic shorten_of(input logic [7:0] i, input logic [7:0] t);
    logic r;
    logic found;
    r = 1'b0;
    found = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (!found && i[k]) begin
        found = 1'b1;
        r = t[7 - k];
      end
    end
    return r;
  endfunction

  always_comb begin
    n = s;
    // three-stage synchroniser; a change counts once stages two and three agree
    n.sync[0] = ext_tick;
    n.sync[1] = s.sync[0];
    n.sync[2] = s.sync[1];
    agree = ~(s.sync[1] ^ s.sync[2]);
    n.ext_lvl = (agree & s.sync[2]) | (~agree & s.ext_lvl);
    ext_rise = agree & s.sync[2] & ~s.ext_lvl;

    // tick: selected source, then divide by 1, 2, 4 or 8
    if (s.clk_src == dwp_pkg::SRC_PCLK) begin
      src_ev = 1'b1;
    end else begin
      src_ev = ext_rise[s.clk_src - 2'h1];
    end
    div_mask = ~({PRESC_W{1'b1}} << s.clk_div);
    tick = s.on && src_ev && ((s.presc & div_mask) == div_mask);
    if (!s.on) begin
      n.presc = '0;
    end else if (src_ev) begin
      n.presc = s.presc + 1'b1;
    end

    // read mux
    rd_hit = 1'b1;
    rd_val = '0;
    unique case (apb_req.paddr)
      dwp_pkg::OFS_CTRL: begin
        rd_val[dwp_pkg::CTRL_ON] = s.on;
        rd_val[dwp_pkg::CTRL_MODE +: 2] = s.mode;
        rd_val[dwp_pkg::CTRL_TRIG +: 2] = s.trig;
        rd_val[dwp_pkg::CTRL_OE +: 2] = s.oe_en;
      end
      dwp_pkg::OFS_SEL: rd_val[7:0] = s.sel;
      dwp_pkg::OFS_CLK: begin
        rd_val[dwp_pkg::CLK_SRC +: 2] = s.clk_src;
        rd_val[dwp_pkg::CLK_DIV +: 2] = s.clk_div;
        rd_val[dwp_pkg::CLK_DIR +: 2] = s.pin_dir;
      end
      dwp_pkg::OFS_STAT: begin
        rd_val[dwp_pkg::STAT_FLAG] = s.flag;
        rd_val[dwp_pkg::STAT_IEN] = s.irq_en;
        rd_val[dwp_pkg::STAT_DITH] = s.dith;
        rd_val[dwp_pkg::STAT_UD] = s.ud;
        rd_val[dwp_pkg::STAT_DOWN] = s.dir_down;
      end
      dwp_pkg::OFS_CNT_H: rd_val[7:0] = s.cnt[15:8];
      dwp_pkg::OFS_CNT_L: rd_val[7:0] = s.cnt[7:0];
      dwp_pkg::OFS_PER_H: rd_val[7:0] = s.per[15:8];
      dwp_pkg::OFS_PER_L: rd_val[7:0] = s.per[7:0];
      dwp_pkg::OFS_DUTY_H: rd_val[7:0] = s.duty[15:8];
      dwp_pkg::OFS_DUTY_L: rd_val[7:0] = s.duty[7:0];
      dwp_pkg::OFS_TRIM_H: rd_val[7:0] = s.trim[15:8];
      dwp_pkg::OFS_TRIM_L: rd_val[7:0] = s.trim[7:0];
      default: rd_hit = 1'b0;
    endcase

    // one wait state: pready rises on the second access cycle
    acc = apb_req.psel && apb_req.penable;
    n.rsp.pready = acc && !s.rsp.pready;
    n.rsp.prdata = (acc && !s.rsp.pready && !apb_req.pwrite) ? rd_val : '0;
    n.rsp.pslverr = acc && !s.rsp.pready && !rd_hit;
    wr = acc && s.rsp.pready && apb_req.pwrite && !s.rsp.pslverr;

    ctrl_wr = wr && (apb_req.paddr == dwp_pkg::OFS_CTRL);
    clr = ctrl_wr && apb_req.pwdata[dwp_pkg::CTRL_CLR];
    restart = ctrl_wr && !s.on && apb_req.pwdata[dwp_pkg::CTRL_ON];
    w1c = wr && (apb_req.paddr == dwp_pkg::OFS_STAT) && apb_req.pwdata[dwp_pkg::STAT_FLAG];
    if (ctrl_wr) begin
      n.on = apb_req.pwdata[dwp_pkg::CTRL_ON];
      n.mode = apb_req.pwdata[dwp_pkg::CTRL_MODE +: 2];
      n.trig = apb_req.pwdata[dwp_pkg::CTRL_TRIG +: 2];
      n.oe_en = apb_req.pwdata[dwp_pkg::CTRL_OE +: 2];
    end
    if (wr) begin
      unique case (apb_req.paddr)
        dwp_pkg::OFS_SEL: n.sel = apb_req.pwdata[7:0];
        dwp_pkg::OFS_CLK: begin
          n.clk_src = apb_req.pwdata[dwp_pkg::CLK_SRC +: 2];
          n.clk_div = apb_req.pwdata[dwp_pkg::CLK_DIV +: 2];
          n.pin_dir = apb_req.pwdata[dwp_pkg::CLK_DIR +: 2];
        end
        dwp_pkg::OFS_STAT: n.irq_en = apb_req.pwdata[dwp_pkg::STAT_IEN];
        // high bytes wait in a shadow until the low byte commits the word
        dwp_pkg::OFS_PER_H: n.hi_shadow[0] = apb_req.pwdata[7:0];
        dwp_pkg::OFS_DUTY_H: n.hi_shadow[1] = apb_req.pwdata[7:0];
        dwp_pkg::OFS_TRIM_H: n.hi_shadow[2] = apb_req.pwdata[7:0];
        dwp_pkg::OFS_PER_L: n.per = {s.hi_shadow[0], apb_req.pwdata[7:0]};
        dwp_pkg::OFS_DUTY_L: n.duty = {s.hi_shadow[1], apb_req.pwdata[7:0]};
        dwp_pkg::OFS_TRIM_L: n.trim = {s.hi_shadow[2], apb_req.pwdata[7:0]};
        default: n.on = n.on;
      endcase
    end

    // counter core
    ovf = 1'b0;
    cnt_lo_inc = s.cnt[7:0] + 8'h01;
    shorten = (s.idx != 8'h00) && shorten_of(s.idx, s.lt);
    duty_eff = s.ld + {7'h00, shorten};
    if (restart || clr) begin
      n.cnt = '0;
      n.dir_down = 1'b0;
      n.idx = '0;
      n.lp = n.per[7:0];
      n.ld = n.duty[7:0];
      n.lt = n.trim[7:0];
      // period zero is never shortened, so duty zero is high from count zero
      n.dith = (n.duty[7:0] == 8'h00);
      n.ud = 1'b0;
    end else if (tick && s.trig == dwp_pkg::TRIG_ALWAYS) begin
      if (s.mode == dwp_pkg::MODE_8P8) begin
        if (s.cnt[7:0] == s.lp) begin
          n.dith = (n.duty[7:0] == 8'h00) && !shorten_of(s.idx + 8'h01, n.trim[7:0]);
          ovf = 1'b1;
          n.cnt = '0;
          n.idx = s.idx + 8'h01;
          n.lp = n.per[7:0];
          n.ld = n.duty[7:0];
          n.lt = n.trim[7:0];
        end else begin
          // rise as the count enters the duty value: high lasts per - duty + 1 ticks
          if (cnt_lo_inc == duty_eff) begin
            n.dith = 1'b1;
          end
          n.cnt = {8'h00, s.cnt[7:0] + 8'h01};
        end
      end else if (s.mode == dwp_pkg::MODE_17BIT) begin
        if (!s.dir_down) begin
          if (s.cnt == s.trim) begin
            n.ud = 1'b1;
          end else if (s.cnt == s.duty) begin
            n.ud = 1'b0;
          end
          if (s.cnt == s.per) begin
            n.dir_down = (s.per != 16'h0000);
            ovf = (s.per == 16'h0000);
            n.cnt = (s.per == 16'h0000) ? s.cnt : s.cnt - 16'h0001;
          end else begin
            n.cnt = s.cnt + 16'h0001;
          end
        end else if (s.cnt == 16'h0000) begin
          ovf = 1'b1;
          n.dir_down = 1'b0;
          n.cnt = 16'h0001;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end
    end

    // overflow event beats a same-cycle clear
    n.flag = ovf || (s.flag && !w1c);
    n.irq = n.flag && n.irq_en;

    // pin routing
    wave = 1'b0;
    wsel = '0;
    for (int p = 0; p < 2; p++) begin
      wsel = s.sel[p * dwp_pkg::SEL_NIB + dwp_pkg::SEL_WSEL +: 3];
      if (wsel == dwp_pkg::WSEL_DITHER && s.mode == dwp_pkg::MODE_8P8 &&
          s.trig == dwp_pkg::TRIG_ALWAYS) begin
        wave = s.dith;
      end else if (wsel == dwp_pkg::WSEL_UPDOWN && s.mode == dwp_pkg::MODE_17BIT &&
                   s.trig == dwp_pkg::TRIG_ALWAYS) begin
        wave = s.ud;
      end else begin
        wave = 1'b0;
      end
      n.pin_out[p] = s.sel[p * dwp_pkg::SEL_NIB + dwp_pkg::SEL_PHASE] ? wave : ~wave;
      n.pin_oe[p] = n.on && n.oe_en[p] && n.pin_dir[p];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign apb_rsp = s.rsp;
  assign pin_out = s.pin_out;
  assign pin_oe = s.pin_oe;
  assign irq = s.irq;

  // 8+8 period end sets the flag and restarts the count
  chk_ovf_period_end: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s.trig == dwp_pkg::TRIG_ALWAYS && s.mode == dwp_pkg::MODE_8P8 &&
     s.cnt[7:0] == s.lp && !restart && !clr) |=>
    (s.flag && s.cnt == 16'h0000 && s.dith == (s.ld == 8'h00 && duty_eff == 8'h00)))
    else $error("8+8 period end did not flag and restart");

  chk_duty_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s.trig == dwp_pkg::TRIG_ALWAYS && s.mode == dwp_pkg::MODE_8P8 &&
     cnt_lo_inc == duty_eff && s.cnt[7:0] != s.lp && !restart && !clr) |=> s.dith)
    else $error("dithered wave did not rise at duty match");

  chk_dither_index: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf && s.mode == dwp_pkg::MODE_8P8) |=> (s.idx == $past(s.idx) + 8'h01))
    else $error("dither index did not advance");

  chk_first_full: assert property (@(posedge pclk) disable iff (!presetn)
    (s.idx == 8'h00) |-> (duty_eff == s.ld))
    else $error("period zero was shortened");

  chk_off_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (!s.on && !ctrl_wr) |=> (s.pin_oe == 2'h0 && $stable(s.cnt)))
    else $error("stopped timer drove a pin or counted");

  chk_clear_count: assert property (@(posedge pclk) disable iff (!presetn)
    clr |=> (s.cnt == 16'h0000 && s.idx == 8'h00) ##1 (s.cnt[15:8] == 8'h00))
    else $error("count clear did not zero the counter");

  chk_ud_reverse: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s.trig == dwp_pkg::TRIG_ALWAYS && s.mode == dwp_pkg::MODE_17BIT &&
     !s.dir_down && s.cnt == s.per && s.per != 16'h0000 && !restart && !clr)
    |=> (s.dir_down && s.cnt == $past(s.per) - 16'h0001))
    else $error("up/down counter did not reverse at period");

  chk_ud_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s.trig == dwp_pkg::TRIG_ALWAYS && s.mode == dwp_pkg::MODE_17BIT &&
     s.dir_down && s.cnt == 16'h0000 && !restart && !clr)
    |=> (s.flag && !s.dir_down) ##1 (s.irq == s.irq_en || !s.flag))
    else $error("up/down zero did not raise overflow");

  chk_low_commit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && apb_req.paddr == dwp_pkg::OFS_PER_H) |=> (s.per == $past(s.per)))
    else $error("high byte write changed the period");

endmodule // dwp_wave_timer

`default_nettype wire

// ### sim/testbench.sv
// testbench: self-checking bench for dwp_wave_timer, driving APB and sampling pins.
// assumes ext_tick[0] rises every four clocks; the other ext_tick inputs stay low.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk;
  logic presetn;
  dwp_pkg::dwp_apb_req_t req;
  dwp_pkg::dwp_apb_rsp_t rsp;
  logic [2:0] ext_tick;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic irq;
  int fails;
  int total_checks;
  logic [31:0] rd;
  logic err;
  int wid[8];
  int gap[8];
  logic [1:0] ext_div = 2'h0;

  dwp_wave_timer #(.PRESC_W(3)) i_dwp_wave_timer (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_tick(ext_tick), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // free-running external tick source, ignored unless source 1 is selected
  always @(posedge pclk) begin
    ext_div <= ext_div + 2'h1;
    ext_tick <= {2'h0, ext_div[1]};
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      check(32'h1, 32'h0);
      complete_run();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  function automatic int tz(int i);
    int z;
    z = 0;
    while (i % 2 == 0 && z < 8) begin
      i = i / 2;
      z++;
    end
    return z;
  endfunction

  // widths of 8 whole high runs on pin 0 and spacing of their falling edges
  task automatic measure();
    int k, run, last, t, ok;
    k = 0;
    run = 0;
    last = 0;
    ok = 0;
    for (t = 0; t < 2000 && k < 8; t++) begin
      @(posedge pclk);
      check({31'h0, pin_out[1]}, {31'h0, ~pin_out[0]});
      if (pin_out[0] === 1'b1) begin
        run += ok;
      end else begin
        if (run > 0) begin
          wid[k] = run;
          gap[k] = t - last;
          last = t;
          k++;
        end
        run = 0;
        ok = 1;
      end
    end
    if (k < 8) begin
      check(32'h1, 32'h0);
      complete_run();
    end
  endtask

  task automatic reset_state();
    check({30'h0, pin_oe}, 32'h0);
    apb(1'b0, dwp_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 6'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask

  // 8+8 mode: period 3, duty 1, pin 0 in phase, pin 1 inverted
  task automatic dither_run(input logic [7:0] trim, input int div, input int src);
    int i, e, m;
    m = (src != 0) ? 4 : (1 << div);
    wr(dwp_pkg::OFS_CTRL, 32'h0);
    wr(dwp_pkg::OFS_CLK, 32'h30 | (div << 2) | src);
    wr(dwp_pkg::OFS_SEL, 32'h4C);
    wr(dwp_pkg::OFS_PER_H, 32'h0);
    wr(dwp_pkg::OFS_PER_L, 32'h3);
    wr(dwp_pkg::OFS_DUTY_H, 32'h0);
    wr(dwp_pkg::OFS_DUTY_L, 32'h1);
    wr(dwp_pkg::OFS_TRIM_H, 32'h0);
    wr(dwp_pkg::OFS_TRIM_L, {24'h0, trim});
    wr(dwp_pkg::OFS_STAT, 32'h3);
    wr(dwp_pkg::OFS_CTRL, 32'hE3);
    measure();
    for (i = 0; i < 8; i++) begin
      e = ((i != 0 && trim[7 - tz(i)]) ? 2 : 3) * m;
      check(wid[i], e);
      if (i > 0) begin
        check(gap[i], 4 * m);
      end
    end
    check({30'h0, pin_oe}, 32'h3);
    check({31'h0, irq}, 32'h1);
  endtask

  // up/down: period 6, raise at 2, drop at 4; a lone high-byte write must not commit
  task automatic updown_run();
    int i;
    wr(dwp_pkg::OFS_CTRL, 32'h0);
    wr(dwp_pkg::OFS_CLK, 32'h30);
    wr(dwp_pkg::OFS_SEL, 32'h5D);
    wr(dwp_pkg::OFS_PER_H, 32'h0);
    wr(dwp_pkg::OFS_PER_L, 32'h6);
    wr(dwp_pkg::OFS_PER_H, 32'h1);
    wr(dwp_pkg::OFS_DUTY_H, 32'h0);
    wr(dwp_pkg::OFS_DUTY_L, 32'h4);
    wr(dwp_pkg::OFS_TRIM_H, 32'h0);
    wr(dwp_pkg::OFS_TRIM_L, 32'h2);
    wr(dwp_pkg::OFS_STAT, 32'h3);
    wr(dwp_pkg::OFS_CTRL, 32'hA3);
    measure();
    for (i = 1; i < 8; i++) begin
      check(wid[i], 2);
      check(gap[i], 12);
    end
    check({31'h0, irq}, 32'h1);
  endtask

  task automatic stop_and_clear();
    wr(dwp_pkg::OFS_CTRL, 32'h0);
    wr(dwp_pkg::OFS_CTRL, 32'h04);
    apb(1'b0, dwp_pkg::OFS_CNT_L, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, dwp_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    wr(dwp_pkg::OFS_STAT, 32'h3);
    apb(1'b0, dwp_pkg::OFS_STAT, 32'h0);
    check(rd & 32'h3, 32'h2);
    check({31'h0, irq}, 32'h0);
    check({30'h0, pin_oe}, 32'h0);
  endtask

  initial begin
    presetn = 1'b0;
    req = '0;
    fails = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_state();
    dither_run(8'h00, 0, 0);
    dither_run(8'h80, 0, 0);
    dither_run(8'hC0, 0, 0);
    dither_run(8'hA0, 0, 0);
    dither_run(8'h00, 1, 0);
    dither_run(8'h00, 0, 1);
    updown_run();
    stop_and_clear();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
